//--- bench/btal_sva.sv
// assertions on the channel link between the processor end and the adapter end
`timescale 1ns/100ps
module btal_sva (
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire logic [15:0] addr_function_word,
  input wire logic [15:0] strobe_control_word,
  input wire logic [2:0]  pairs_queued,
  input wire logic        seq_active
);
  wire logic [3:0] stb = strobe_control_word[3:0]; // the four strobe bits
  logic            sds_seen;                       // an opening start went across
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // sticky since reset: a sequence may not open before any opening start was strobed
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) sds_seen <= 1'b0;
    else if (stb[0] && addr_function_word[0] && (strobe_control_word[15:12] == btal_pkg::CONN_DEFAULT))
      sds_seen <= 1'b1;
  end
  // set and clear: high for one cycle, low again at once
  sequence s_pulse(b);
    b ##1 !b;
  endsequence
  property p_start_pulse; $rose(stb[0]) |-> s_pulse(stb[0]); endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start strobe not a pulse");
  property p_term_pulse; $rose(stb[1]) |-> s_pulse(stb[1]); endproperty
  a_term_pulse: assert property (p_term_pulse) else $error("end strobe not a pulse");
  property p_func_pulse; $rose(stb[2]) |-> s_pulse(stb[2]); endproperty
  a_func_pulse: assert property (p_func_pulse) else $error("function strobe not a pulse");
  property p_one_strobe; $onehot0(stb); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes at once");
  // the word must already stand when its strobe rises, or the wrong value is caught
  property p_word_setup; $rose(|stb[2:0]) |-> $stable(addr_function_word); endproperty
  a_word_setup: assert property (p_word_setup) else $error("word changed under strobe");
  property p_conn_hold; $rose(|stb[2:0]) |-> $stable(strobe_control_word[15:12]); endproperty
  a_conn_hold: assert property (p_conn_hold) else $error("connect code moved at strobe");
  property p_queue_max; pairs_queued <= 3'h4; endproperty
  a_queue_max: assert property (p_queue_max) else $error("more than four pairs queued");
  // a pair only enters the queue a few cycles after an end strobe
  property p_queue_grow;
    (pairs_queued > $past(pairs_queued)) |-> ($past(stb[1]) || $past(stb[1], 2) || $past(stb[1], 3) || $past(stb[1], 4));
  endproperty
  a_queue_grow: assert property (p_queue_grow) else $error("queue grew without end strobe");
  property p_seq_open; $rose(seq_active) |-> sds_seen; endproperty
  a_seq_open: assert property (p_seq_open) else $error("sequence opened without flag");
  property p_spare_zero; strobe_control_word[11:4] == 8'h00; endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("spare control bits set");
endmodule : btal_sva

//--- bench/tb_top.sv
// self-checking bench: ahb host end drives the adapter end over the link
`timescale 1ns/100ps
module tb_top;
  logic        clk_sys_in;                 // 250 mhz system clock
  logic        reset_n_in;                 // active low reset
  logic        hsel, hwrite, hready, hresp; // ahb control
  logic [1:0]  htrans;                     // ahb transfer kind
  logic [31:0] haddr, hwdata, hrdata, rd;  // ahb address, data and last read
  logic        mem_rd, stor_valid, stor_ready, func_stb, seq_act, seq_done;
  logic [14:0] mem_addr, func_code;        // memory address, function code
  logic [15:0] mem_data, stor_data;        // memory answer, storage word
  logic [2:0]  pairs;                      // queue level
  logic [15:0] got[$], exp[$];             // words seen at and owed to storage
  logic [14:0] st[6] = '{15'h100, 15'h200, 15'h300, 15'h400, 15'h500, 15'h600}; // block starts
  logic [14:0] en[6] = '{15'h10b, 15'h201, 15'h302, 15'h400, 15'h501, 15'h601}; // block ends
  int          failures, samples_checked, func_n, done_n, rd_n;
  btal_link_if link ();
  btal_host u_btal_host (.clk_sys_in, .reset_n_in, .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .link(link.host));
  btal_device u_btal_device (.clk_sys_in, .reset_n_in, .link(link.dev), .mem_addr_out(mem_addr),
    .mem_rd_out(mem_rd), .mem_data_in(mem_data), .stor_data_out(stor_data), .stor_valid_out(stor_valid),
    .stor_ready_in(stor_ready), .func_code_out(func_code), .func_strobe_out(func_stb),
    .seq_active_out(seq_act), .seq_done_out(seq_done), .pairs_queued_out(pairs));
  btal_sva u_btal_sva (.clk_sys_in, .reset_n_in, .addr_function_word(link.addr_function_word),
    .strobe_control_word(link.strobe_control_word), .pairs_queued(link.pairs_queued),
    .seq_active(link.seq_active));
  // free running clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  // memory reads without delay: the adapter takes the word while its read pulse stands
  assign mem_data = {1'b1, mem_addr};
  // reads, words and pulses are gathered at each edge
  always @(posedge clk_sys_in) begin
    if (mem_rd === 1'b1) rd_n++;
    if (stor_valid === 1'b1 && stor_ready === 1'b1) got.push_back(stor_data);
    if (func_stb === 1'b1) func_n++;
    if (seq_done === 1'b1) done_n++;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic give_up;
    failures++;
    $display("Error wait expected done seen timeout");
    tally_and_finish();
  endtask : give_up
  // next edge with hready sampled high; bounded so a stuck slave ends the run
  task automatic hop;
    int n;
    n = 0;
    @(posedge clk_sys_in);
    while (hready !== 1'b1) begin
      n++;
      if (n > 64) give_up();
      @(posedge clk_sys_in);
    end
  endtask : hop
  // one single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= btal_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hop();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hop();
    rd = hrdata;
  endtask : ahb
  // one command, then poll busy until the host end has strobed it out
  task automatic cmd(input logic [1:0] kind, input logic flag, input logic [14:0] v);
    int n;
    ahb(1'b1, btal_pkg::REG_CMD, {14'h0, kind, flag, v});
    n = 0;
    do begin
      ahb(1'b0, btal_pkg::REG_STATUS, 32'h0);
      n++;
      if (n > 40) give_up();
    end while (rd[btal_pkg::ST_BUSY_BIT] !== 1'b0);
  endtask : cmd
  initial begin
    int n;
    reset_n_in = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    stor_ready = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    // status, connect code and an unmapped word read zero after reset
    ahb(1'b0, btal_pkg::REG_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    ahb(1'b0, btal_pkg::REG_CONNECT, 32'h0);
    chk("connect", rd, 32'h0);
    ahb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", rd, 32'h0);
    // an end with no start is refused, and the flag clears on write one
    cmd(btal_pkg::KIND_TERM, 1'b0, 15'h10);
    ahb(1'b0, btal_pkg::REG_STATUS, 32'h0);
    chk("refused", rd, 32'h2);
    chk("okay", hresp, 1'b0);
    ahb(1'b1, btal_pkg::REG_STATUS, 32'h2);
    ahb(1'b0, btal_pkg::REG_STATUS, 32'h0);
    chk("refuse clear", rd, 32'h0);
    // a foreign connect code: the adapter ignores the pair
    ahb(1'b1, btal_pkg::REG_CONNECT, 32'h3);
    cmd(btal_pkg::KIND_START, 1'b1, 15'h700);
    cmd(btal_pkg::KIND_TERM, 1'b1, 15'h701);
    repeat (8) @(posedge clk_sys_in);
    chk("foreign queue", pairs, 3'h0);
    chk("foreign seq", seq_act, 1'b0);
    ahb(1'b1, btal_pkg::REG_CONNECT, 32'h2);
    ahb(1'b0, btal_pkg::REG_CONNECT, 32'h0);
    chk("connect back", rd, 32'h2);
    // storage stalls: first block sticks, four pairs queue, the sixth is dropped
    for (int i = 0; i < 6; i++) begin
      cmd(btal_pkg::KIND_START, i == 0, st[i]);
      cmd(btal_pkg::KIND_TERM, i == 4, en[i]);
      if (i < 5) for (int a = st[i]; a <= en[i]; a++) exp.push_back({1'b1, a[14:0]});
    end
    chk("queue full", pairs, 3'h4);
    chk("link level", link.pairs_queued, 3'h4);
    chk("seq open", seq_act, 1'b1);
    // the same bits under the function strobe become a function code, not a pair
    cmd(btal_pkg::KIND_FUNC, 1'b0, 15'h1abc);
    chk("func code", func_code, 15'h1abc);
    chk("func pulses", func_n, 1);
    chk("func not queued", pairs, 3'h4);
    // drain with storage ready toggling, so the far side keeps stalling
    for (n = 0; n < 800 && got.size() < exp.size(); n++) begin
      stor_ready <= ~stor_ready;
      @(posedge clk_sys_in);
    end
    stor_ready <= 1'b1;
    repeat (40) @(posedge clk_sys_in);
    chk("word count", got.size(), exp.size());
    chk("reads", rd_n, exp.size());
    foreach (exp[i]) chk("word", got[i], exp[i]);
    chk("seq done", done_n, 1);
    chk("seq closed", seq_act, 1'b0);
    chk("queue empty", pairs, 3'h0);
    // program clear while stalled: queued pair and open sequence are dropped
    stor_ready <= 1'b0;
    cmd(btal_pkg::KIND_START, 1'b1, st[0]);
    cmd(btal_pkg::KIND_TERM, 1'b0, en[0]);
    cmd(btal_pkg::KIND_START, 1'b0, st[1]);
    cmd(btal_pkg::KIND_TERM, 1'b1, en[1]);
    chk("pre clear queue", pairs, 3'h1);
    cmd(btal_pkg::KIND_CLEAR, 1'b0, 15'h0);
    chk("clear queue", pairs, 3'h0);
    chk("clear seq", seq_act, 1'b0);
    tally_and_finish();
  end
endmodule : tb_top

//--- inc/btal_link_if.sv
// channel link between the station control processor end and the adapter end
`timescale 1ns/100ps
interface btal_link_if;
  logic [15:0] addr_function_word;   // address / function word, host driven
  logic [15:0] strobe_control_word;  // strobes and connect code, host driven
  logic [2:0]  pairs_queued;         // adapter queue level
  logic        seq_active;           // adapter is inside a sequence
  modport host (output addr_function_word, output strobe_control_word, input pairs_queued, input seq_active);
  modport dev  (input addr_function_word, input strobe_control_word, output pairs_queued, output seq_active);
endinterface : btal_link_if

//--- inc/btal_pkg.sv
// shared constants for the block transfer address loader, both ends
package btal_pkg;
  localparam int          WORD_W        = 16;     // channel word width
  localparam int          ADDR_W        = 15;     // buffer memory address width
  localparam int          FLAG_BIT      = 0;      // sequence flag position in address word
  localparam int          ADDR_LSB      = 1;      // address / function field low bit
  localparam int          STB_START     = 0;      // strobe bit: starting address
  localparam int          STB_TERM      = 1;      // strobe bit: terminating address
  localparam int          STB_FUNC      = 2;      // strobe bit: function code
  localparam int          STB_CLEAR     = 3;      // strobe bit: program clear
  localparam int          CONN_LSB      = 12;     // connect code field low bit
  localparam int          CONN_W        = 4;      // connect code width
  localparam logic [3:0]  CONN_DEFAULT  = 4'h2;   // default code this adapter answers to
  localparam int          PAIR_DEPTH    = 4;      // queued address pairs
  localparam int          FIFO_DEPTH    = 8;      // words buffered toward storage
  localparam int          SETUP_CYC     = 2;      // cycles word stands before its strobe
  // host register byte offsets
  localparam logic [7:0]  REG_CMD       = 8'h00;  // command: kind, flag, 15-bit value
  localparam logic [7:0]  REG_CONNECT   = 8'h04;  // connect code
  localparam logic [7:0]  REG_STATUS    = 8'h08;  // busy, refused, queue level, sequence
  // command register fields
  localparam int          CMD_FLAG_BIT  = 15;     // sequence flag in command
  localparam int          CMD_KIND_LSB  = 16;     // command kind, two bits
  localparam logic [1:0]  KIND_START    = 2'h0;
  localparam logic [1:0]  KIND_TERM     = 2'h1;
  localparam logic [1:0]  KIND_FUNC     = 2'h2;
  localparam logic [1:0]  KIND_CLEAR    = 2'h3;
  // status register fields
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_REFUSE_BIT = 1;      // write 1 to clear
  localparam int          ST_SEQ_BIT    = 2;
  localparam int          ST_LVL_LSB    = 4;      // three bits of queue level
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage : btal_pkg

//--- rtl/btal_device.sv
// adapter end: strobe capture, address pair queue, block streamer and output fifo
// Overview of operation
// - queue up to four start/end pairs
// - processor feeds pairs early for continuity
// - start address in bits; flag first only
// - bit 0 strobe captures starting address
// - end address follows its start; flag last
// - bit 1 strobe captures terminating address
// - order: start, strobe, end, strobe
// - end flag closes sequence after block
// - start flag opens sequence, blocks stream
// - end address bits 1..F, last word
// - start address bits 1..F, first word
// - same bits carry function code too
// - bit 2 strobe captures function code
// - strobes are pulses, never left set
// - only matching connect code responds
`timescale 1ns/100ps
module btal_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [PW-1:0]    wr_ptr;        // next slot to fill
  logic [PW-1:0]    rd_ptr;        // oldest slot
  logic [PW:0]      count;         // words held
  logic             push;
  logic             pop;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign in_ready_out  = (count != (PW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];

  // storage write, no reset needed for data
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // pointers and level
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= PW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= (PW+1)'(count + 1'b1);
      end else if (pop && !push) begin
        count <= (PW+1)'(count - 1'b1);
      end
    end
  end
endmodule : btal_fifo

module btal_device #(
  parameter logic [3:0] CONNECT_CODE = btal_pkg::CONN_DEFAULT
) (
  input  wire logic                       clk_sys_in,
  input  wire logic                       reset_n_in,
  btal_link_if.dev                        link,
  output logic [btal_pkg::ADDR_W-1:0]     mem_addr_out,
  output logic                            mem_rd_out,
  input  wire logic [btal_pkg::WORD_W-1:0] mem_data_in,
  output logic [btal_pkg::WORD_W-1:0]     stor_data_out,
  output logic                            stor_valid_out,
  input  wire logic                       stor_ready_in,
  output logic [btal_pkg::ADDR_W-1:0]     func_code_out,
  output logic                            func_strobe_out,
  output logic                            seq_active_out,
  output logic                            seq_done_out,
  output logic [2:0]                      pairs_queued_out
);
  typedef enum logic {BTAL_IDLE, BTAL_RUN} btal_state_t;

  localparam int AW = btal_pkg::ADDR_W;
  logic [15:0]   prev_scw;                  // strobe word one cycle ago
  logic          connected;                 // connect code matches
  logic [3:0]    rise;                      // strobe rising edges
  logic [AW-1:0] hold_start;                // captured start awaiting its end
  logic          hold_sds;                  // start-of-sequence flag of held start
  logic          have_start;                // a start is waiting for its end
  logic [AW-1:0] q_start [btal_pkg::PAIR_DEPTH];
  logic [AW-1:0] q_end   [btal_pkg::PAIR_DEPTH];
  logic          q_sds   [btal_pkg::PAIR_DEPTH];
  logic          q_eds   [btal_pkg::PAIR_DEPTH];
  logic [1:0]    q_wr;                      // queue write slot
  logic [1:0]    q_rd;                      // queue head slot
  logic [2:0]    q_cnt;                     // pairs queued
  logic          q_push;
  logic          q_pop;
  btal_state_t   state;
  logic [AW-1:0] cur_addr;                  // word being fetched
  logic [AW-1:0] end_addr;                  // last word of current block
  logic          cur_eds;                   // current block ends the sequence
  logic          rd_pend;                   // memory word arrives this cycle
  logic          fifo_ready;
  logic          fetch;
  logic          clear;

  assign connected = (link.strobe_control_word[btal_pkg::CONN_LSB +: btal_pkg::CONN_W] == CONNECT_CODE);
  assign rise      = link.strobe_control_word[3:0] & ~prev_scw[3:0] & {4{connected}};
  assign clear     = rise[btal_pkg::STB_CLEAR];
  // end strobe completes a pair only if its start came first; a full queue drops it
  assign q_push    = rise[btal_pkg::STB_TERM] && have_start && (q_cnt != 3'(btal_pkg::PAIR_DEPTH));
  assign q_pop     = (state == BTAL_IDLE) && (q_cnt != 3'h0) && !clear;
  assign fetch     = (state == BTAL_RUN) && fifo_ready && !rd_pend && !clear;
  assign link.pairs_queued = pairs_queued_out;
  assign link.seq_active   = seq_active_out;

  // edge history; falling edges are never acted on, so each set/clear pulse loads once
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prev_scw <= 16'h0000;
    end else begin
      prev_scw <= link.strobe_control_word;
    end
  end

  // starting address capture, held until its terminating partner arrives
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_start <= '0;
      hold_sds   <= 1'b0;
      have_start <= 1'b0;
    end else if (clear) begin
      have_start <= 1'b0;
    end else if (rise[btal_pkg::STB_START]) begin
      hold_start <= link.addr_function_word[btal_pkg::ADDR_LSB +: AW];
      hold_sds   <= link.addr_function_word[btal_pkg::FLAG_BIT];
      have_start <= 1'b1;
    end else if (rise[btal_pkg::STB_TERM]) begin
      have_start <= 1'b0;
    end
  end

  // pair queue storage
  always_ff @(posedge clk_sys_in) begin
    if (q_push) begin
      q_start[q_wr] <= hold_start;
      q_end[q_wr]   <= link.addr_function_word[btal_pkg::ADDR_LSB +: AW];
      q_sds[q_wr]   <= hold_sds;
      q_eds[q_wr]   <= link.addr_function_word[btal_pkg::FLAG_BIT];
    end
  end

  // pair queue pointers; program clear empties it
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_wr  <= 2'h0;
      q_rd  <= 2'h0;
      q_cnt <= 3'h0;
    end else if (clear) begin
      q_wr  <= 2'h0;
      q_rd  <= 2'h0;
      q_cnt <= 3'h0;
    end else begin
      if (q_push) begin
        q_wr <= 2'(q_wr + 1'b1);
      end
      if (q_pop) begin
        q_rd <= 2'(q_rd + 1'b1);
      end
      if (q_push && !q_pop) begin
        q_cnt <= 3'(q_cnt + 1'b1);
      end else if (q_pop && !q_push) begin
        q_cnt <= 3'(q_cnt - 1'b1);
      end
    end
  end

  // function code register; pulse marks a fresh code
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      func_code_out   <= '0;
      func_strobe_out <= 1'b0;
    end else begin
      func_strobe_out <= rise[btal_pkg::STB_FUNC];
      if (rise[btal_pkg::STB_FUNC]) begin
        func_code_out <= link.addr_function_word[btal_pkg::ADDR_LSB +: AW];
      end
    end
  end

  // block streamer: walks each pair from start to end, one read per free fifo slot
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state          <= BTAL_IDLE;
      cur_addr       <= '0;
      end_addr       <= '0;
      cur_eds        <= 1'b0;
      seq_active_out <= 1'b0;
      seq_done_out   <= 1'b0;
    end else begin
      seq_done_out <= 1'b0;
      if (clear) begin
        state          <= BTAL_IDLE;
        seq_active_out <= 1'b0;
      end else begin
        case (state)
          BTAL_IDLE: begin
            if (q_pop) begin
              cur_addr <= q_start[q_rd];
              end_addr <= q_end[q_rd];
              cur_eds  <= q_eds[q_rd];
              state    <= BTAL_RUN;
              if (q_sds[q_rd]) begin
                seq_active_out <= 1'b1;
              end
            end
          end
          BTAL_RUN: begin
            if (fetch) begin
              if (cur_addr == end_addr) begin
                state <= BTAL_IDLE;
                if (cur_eds) begin
                  seq_active_out <= 1'b0;
                  seq_done_out   <= 1'b1;
                end
              end else begin
                cur_addr <= AW'(cur_addr + 1'b1);
              end
            end
          end
          default: begin
            state <= BTAL_IDLE;
          end
        endcase
      end
    end
  end

  // memory read port; one read in flight so the fifo slot seen free stays free
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_rd_out   <= 1'b0;
      mem_addr_out <= '0;
      rd_pend      <= 1'b0;
    end else begin
      mem_rd_out <= fetch;
      rd_pend    <= fetch;
      if (fetch) begin
        mem_addr_out <= cur_addr;
      end
    end
  end

  // queue level shown to both sides
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pairs_queued_out <= 3'h0;
    end else begin
      pairs_queued_out <= q_cnt;
    end
  end

  // word buffer toward the storage device; a stalled device stalls fetching
  btal_fifo #(
    .WIDTH (btal_pkg::WORD_W),
    .DEPTH (btal_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .in_data_in    (mem_data_in),
    .in_valid_in   (rd_pend),
    .in_ready_out  (fifo_ready),
    .out_data_out  (stor_data_out),
    .out_valid_out (stor_valid_out),
    .out_ready_in  (stor_ready_in)
  );
endmodule : btal_device

//--- rtl/btal_host.sv
// processor end: AHB-Lite command registers driving the two channel words
`timescale 1ns/100ps
module btal_host (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  btal_link_if.host        link
);
  typedef enum logic [1:0] {BH_IDLE, BH_SETUP, BH_PULSE, BH_RELEASE} bh_state_t;

  logic        addr_ok;          // valid address phase to this slave
  logic        wr_pend;          // write data phase follows
  logic [7:0]  wr_addr;          // latched write offset
  logic        wr_cmd;           // data phase writes the command register
  logic [1:0]  kind;             // kind of command running
  logic [3:0]  conn_code;        // connect code register
  logic        refused;          // sticky: command out of order or while busy
  logic        expect_term;      // a start was sent, its end is due
  logic        cmd_ok;           // command accepted this cycle
  logic [1:0]  next_kind;
  logic [1:0]  setup_cnt;        // cycles the word has stood
  bh_state_t   state;

  assign addr_ok   = hsel_in && hready_in && (htrans_in == btal_pkg::HTRANS_NONSEQ);
  assign wr_cmd    = wr_pend && (wr_addr == btal_pkg::REG_CMD);
  assign next_kind = hwdata_in[btal_pkg::CMD_KIND_LSB +: 2];
  // starts and ends must alternate; anything else, or a write while busy, is refused
  assign cmd_ok    = wr_cmd && (state == BH_IDLE) &&
                     ((next_kind == btal_pkg::KIND_START) ? !expect_term :
                      (next_kind == btal_pkg::KIND_TERM)  ? expect_term : 1'b1);

  // address phase capture and read data, zero wait states
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pend       <= 1'b0;
      wr_addr       <= 8'h00;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend <= addr_ok && hwrite_in;
      if (addr_ok) begin
        wr_addr <= haddr_in[7:0];
      end
      if (addr_ok && !hwrite_in) begin
        case (haddr_in[7:0])
          btal_pkg::REG_CONNECT: hrdata_out <= {28'h0000000, conn_code};
          btal_pkg::REG_STATUS:  hrdata_out <= {25'h0000000, link.pairs_queued, 1'b0, link.seq_active,
                                                refused, (state != BH_IDLE)};
          default:               hrdata_out <= 32'h0000_0000;  // unmapped and write-only read zero
        endcase
      end
    end
  end

  // connect code register
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      conn_code <= 4'h0;
    end else if (wr_pend && (wr_addr == btal_pkg::REG_CONNECT)) begin
      conn_code <= hwdata_in[3:0];
    end
  end

  // refusal flag; a new refusal wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      refused <= 1'b0;
    end else if (wr_cmd && !cmd_ok) begin
      refused <= 1'b1;
    end else if (wr_pend && (wr_addr == btal_pkg::REG_STATUS) && hwdata_in[btal_pkg::ST_REFUSE_BIT]) begin
      refused <= 1'b0;
    end
  end

  // pairing tracker; program clear forgets a half-sent pair
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      expect_term <= 1'b0;
    end else if (cmd_ok) begin
      if (next_kind == btal_pkg::KIND_START) begin
        expect_term <= 1'b1;
      end else if (next_kind != btal_pkg::KIND_FUNC) begin
        expect_term <= 1'b0;
      end
    end
  end

  // channel sequencer: present word, let it settle, pulse one strobe, release
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state                    <= BH_IDLE;
      kind                     <= 2'h0;
      setup_cnt                <= 2'h0;
      link.addr_function_word  <= 16'h0000;
      link.strobe_control_word <= 16'h0000;
    end else begin
      link.strobe_control_word[btal_pkg::CONN_LSB +: btal_pkg::CONN_W] <= conn_code;
      case (state)
        BH_IDLE: begin
          if (cmd_ok) begin
            kind      <= next_kind;
            setup_cnt <= 2'h0;
            // flag bit carries start/end of sequence as software chose it
            link.addr_function_word <= {hwdata_in[14:0], hwdata_in[btal_pkg::CMD_FLAG_BIT]};
            state     <= BH_SETUP;
          end
        end
        BH_SETUP: begin
          setup_cnt <= 2'(setup_cnt + 1'b1);
          if (setup_cnt == 2'(btal_pkg::SETUP_CYC - 1)) begin
            link.strobe_control_word[kind] <= 1'b1;
            state <= BH_PULSE;
          end
        end
        BH_PULSE: begin
          link.strobe_control_word[3:0] <= 4'h0;
          state <= BH_RELEASE;
        end
        BH_RELEASE: begin
          state <= BH_IDLE;
        end
        default: begin
          state <= BH_IDLE;
        end
      endcase
    end
  end
endmodule : btal_host
